// file: design/pcc_pkg.sv
// pcc_pkg: constants for the pll command control block
package pcc_pkg;
	// register indices as printed, byte address is four times these
	localparam logic [7:0]  PCC_IDX_ALIAS_A  = 8'h15;
	localparam logic [7:0]  PCC_IDX_ALIAS_B  = 8'h50;
	localparam logic [11:0] PCC_ADDR_ALIAS_A = {2'b00, PCC_IDX_ALIAS_A, 2'b00};
	localparam logic [11:0] PCC_ADDR_ALIAS_B = {2'b00, PCC_IDX_ALIAS_B, 2'b00};
	localparam logic [11:0] PCC_ADDR_STATUS  = 12'h0_400;
	// field positions
	localparam int PCC_BIT_OVERRIDE = 7;
	localparam int PCC_BIT_FULL     = 2;
	localparam int PCC_BIT_SMALL    = 1;
	localparam int PCC_BIT_RELOAD   = 0;
	localparam logic [7:0] PCC_CTRL_RESET = 8'h00;
	localparam logic [7:0] PCC_CTRL_MASK  = 8'h87;
	// sequencing times, stand-ins for the analog work
	localparam int PCC_CLK_MHZ       = 20;
	localparam int PCC_STEP_NS       = 500;
	localparam int PCC_CAL_NS        = 2000;
	localparam int PCC_RELOAD_NS     = 1000;
	localparam int PCC_STEP_CYC      = (PCC_STEP_NS * PCC_CLK_MHZ + 999) / 1000;
	localparam int PCC_CAL_CYC       = (PCC_CAL_NS * PCC_CLK_MHZ + 999) / 1000;
	localparam int PCC_RELOAD_CYC    = (PCC_RELOAD_NS * PCC_CLK_MHZ + 999) / 1000;
	localparam int PCC_CW            = 8;
	// frequency word: ratio 4, integer 6, fraction 24 bits
	localparam int PCC_FW            = 34;
	// sequencer states
	typedef enum logic [1:0] {
		PCC_IDLE = 2'b00,
		PCC_STEP = 2'b01,
		PCC_CAL  = 2'b10
	} pcc_seq_t;
endpackage

// file: design/pcc_timer.sv
// pcc_timer: one-shot cycle counter that pulses done when it runs out
`timescale 1ns/1ns
module pcc_timer (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      start,
	input  wire logic [pcc_pkg::PCC_CW-1:0] load,
	output logic                           busy,
	output logic                           done
);
	logic [pcc_pkg::PCC_CW-1:0] count;

	// count down from load; done pulses in the cycle after the count reaches one, as busy drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else if (start) begin
			count <= load;
			busy  <= 1'b1;
			done  <= 1'b0;
		end else if (busy && count <= 8'h01) begin
			count <= '0;
			busy  <= 1'b0;
			done  <= 1'b1;
		end else begin
			count <= busy ? count - 8'h01 : count;
			done  <= 1'b0;
		end
	end
endmodule

// file: design/pcc_top.sv
// pcc_top: apb slave holding the pll command register and its sequencing
`timescale 1ns/1ns
module pcc_top (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       enable_pin,
	input  wire logic                       enable_pin_active_low,
	input  wire logic [pcc_pkg::PCC_FW-1:0] store_word,
	input  wire logic [pcc_pkg::PCC_FW-1:0] user_word_in,
	input  wire logic                       user_word_we,
	output logic      [pcc_pkg::PCC_FW-1:0] user_word,
	output logic      [pcc_pkg::PCC_FW-1:0] pll_word,
	output logic                            calibrate,
	output logic                            clock_buffer_on
);
	logic [7:0]               ctrl;
	logic                     pin_s1;
	logic                     pin_s2;
	logic                     pol_s1;
	logic                     pol_s2;
	pcc_pkg::pcc_seq_t        seq;
	logic                     wr;
	logic                     hit_ctrl;
	logic                     hit_stat;
	logic                     seq_start;
	logic [pcc_pkg::PCC_CW-1:0] seq_load;
	logic                     seq_busy;
	logic                     seq_done;
	logic                     rl_start;
	logic                     rl_busy;
	logic                     rl_done;
	logic                     go_full;
	logic                     go_small;
	logic                     go_reload;

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	function automatic logic pcc_is_ctrl(input logic [11:0] a);
		// both aliases map onto one storage
		pcc_is_ctrl = (a == pcc_pkg::PCC_ADDR_ALIAS_A) ||
			(a == pcc_pkg::PCC_ADDR_ALIAS_B);
	endfunction

	assign hit_ctrl  = pcc_is_ctrl(paddr);
	assign hit_stat  = (paddr == pcc_pkg::PCC_ADDR_STATUS);
	assign wr        = psel && penable && pwrite && hit_ctrl;
	assign pready    = 1'b1; // zero wait states, registers only
	assign go_full   = wr && pwdata[pcc_pkg::PCC_BIT_FULL];
	assign go_small  = wr && pwdata[pcc_pkg::PCC_BIT_SMALL];
	assign go_reload = wr && pwdata[pcc_pkg::PCC_BIT_RELOAD];

	// unmapped addresses answer with an error and zero data
	assign pslverr   = psel && penable && !hit_ctrl && !hit_stat;

	// read data registered at the access phase entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			if (hit_ctrl) begin
				prdata <= {24'h00_0000, ctrl};
			end else if (hit_stat) begin
				prdata <= {29'h0000_0000, rl_busy, seq};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control register; reserved bits 6:3 are dropped, reading zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= pcc_pkg::PCC_CTRL_RESET;
		end else begin
			if (wr) begin
				ctrl[pcc_pkg::PCC_BIT_OVERRIDE] <= pwdata[pcc_pkg::PCC_BIT_OVERRIDE];
			end
			// command bits: a new write of 1 wins over the self-clear
			if (go_full || go_small) begin
				ctrl[pcc_pkg::PCC_BIT_FULL]  <= go_full | ctrl[pcc_pkg::PCC_BIT_FULL];
				ctrl[pcc_pkg::PCC_BIT_SMALL] <= go_small | ctrl[pcc_pkg::PCC_BIT_SMALL];
			end else if (seq_done && (seq == pcc_pkg::PCC_CAL ||
				!ctrl[pcc_pkg::PCC_BIT_FULL])) begin
				// full apply holds its bit through calibration, not just the step
				ctrl[pcc_pkg::PCC_BIT_FULL]  <= 1'b0;
				ctrl[pcc_pkg::PCC_BIT_SMALL] <= 1'b0;
			end
			if (go_reload) begin
				ctrl[pcc_pkg::PCC_BIT_RELOAD] <= 1'b1;
			end else if (rl_done) begin
				ctrl[pcc_pkg::PCC_BIT_RELOAD] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// enable pin and polarity strap are asynchronous; two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pol_s1 <= 1'b0;
			pol_s2 <= 1'b0;
		end else begin
			pin_s1 <= enable_pin;
			pin_s2 <= pin_s1;
			pol_s1 <= enable_pin_active_low;
			pol_s2 <= pol_s1;
		end
	end

	// open pin is pulled to its enabling level outside this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_buffer_on <= 1'b0;
		end else if (pol_s2) begin
			clock_buffer_on <= ctrl[pcc_pkg::PCC_BIT_OVERRIDE] | !pin_s2;
		end else begin
			clock_buffer_on <= ctrl[pcc_pkg::PCC_BIT_OVERRIDE] | pin_s2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frequency sequencer: step, then calibrate when full apply asked
	// a pending command waits out a reload, so 0x05 loads the restored word
	assign seq_start = seq == pcc_pkg::PCC_IDLE && !go_reload && !rl_busy && !rl_done &&
		(go_full || go_small || ctrl[pcc_pkg::PCC_BIT_FULL] ||
		ctrl[pcc_pkg::PCC_BIT_SMALL]);
	assign seq_load  = (seq == pcc_pkg::PCC_STEP && seq_done && ctrl[pcc_pkg::PCC_BIT_FULL])
		? 8'(pcc_pkg::PCC_CAL_CYC) : 8'(pcc_pkg::PCC_STEP_CYC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq       <= pcc_pkg::PCC_IDLE;
			pll_word  <= '0;
			calibrate <= 1'b0;
		end else begin
			case (seq)
				pcc_pkg::PCC_IDLE: begin
					if (seq_start) begin
						pll_word <= user_word;
						seq      <= pcc_pkg::PCC_STEP;
					end
				end
				pcc_pkg::PCC_STEP: begin
					if (seq_done && ctrl[pcc_pkg::PCC_BIT_FULL]) begin
						calibrate <= 1'b1;
						seq       <= pcc_pkg::PCC_CAL;
					end else if (seq_done) begin
						seq <= pcc_pkg::PCC_IDLE;
					end
				end
				pcc_pkg::PCC_CAL: begin
					if (seq_done) begin
						calibrate <= 1'b0;
						seq       <= pcc_pkg::PCC_IDLE;
					end
				end
				default: seq <= pcc_pkg::PCC_IDLE;
			endcase
		end
	end

	// the small-step path only stops at idle; the calibration timer reuses it
	pcc_timer u_seq_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (seq_start || (seq == pcc_pkg::PCC_STEP && seq_done &&
			ctrl[pcc_pkg::PCC_BIT_FULL])),
		.load    (seq_load),
		.busy    (seq_busy),
		.done    (seq_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// reload: user word only, pll word untouched
	assign rl_start = go_reload && !rl_busy;

	// restore wins over a user write landing in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_word <= '0;
		end else if (rl_done) begin
			user_word <= store_word;
		end else if (user_word_we && !rl_busy) begin
			user_word <= user_word_in;
		end
	end

	pcc_timer u_rl_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (rl_start),
		.load    (8'(pcc_pkg::PCC_RELOAD_CYC)),
		.busy    (rl_busy),
		.done    (rl_done)
	);
endmodule

// file: verif/pcc_chk.sv
// pcc_chk: port-level assertions for the pll command block
`timescale 1ns/1ns
module pcc_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        enable_pin,
	input wire logic        enable_pin_active_low,
	input wire logic [33:0] store_word,
	input wire logic [33:0] user_word,
	input wire logic [33:0] pll_word,
	input wire logic        calibrate,
	input wire logic        clock_buffer_on
);
	// write access to either alias of the command register
	wire logic wr = psel && penable && pwrite &&
		(paddr == pcc_pkg::PCC_ADDR_ALIAS_A || paddr == pcc_pkg::PCC_ADDR_ALIAS_B);
	logic [33:0] pll_prev;
	logic        apply_owed;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// an apply may wait out a reload; remember it until the pll word moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_prev   <= '0;
			apply_owed <= 1'b0;
		end else begin
			pll_prev <= pll_word;
			if (wr && pwdata[2:1] != 2'b00) begin
				apply_owed <= 1'b1;
			end else if (pll_word != pll_prev) begin
				apply_owed <= 1'b0;
			end
		end
	end
	////////////////////////////////////////
	// pin held long enough to clear the two sync flops and the output flop
	buf_high_a: assert property ((!enable_pin_active_low && enable_pin) [*4] |=> clock_buffer_on)
		else $error("buffer off with pin high");
	buf_low_a: assert property ((enable_pin_active_low && !enable_pin) [*4] |=> clock_buffer_on)
		else $error("buffer off with pin low");
	pll_hold_a: assert property (pll_word != $past(pll_word) |->
		$past(apply_owed || (wr && pwdata[2:1] != 2'b00)))
		else $error("pll word moved without apply");
	step_load_a: assert property (wr && pwdata[2:0] == 3'b010 && !calibrate |=> pll_word == $past(user_word))
		else $error("small step did not load pll");
	reload_a: assert property (wr && pwdata[0] |-> ##[1:30] user_word == store_word)
		else $error("reload did not restore user word");
	cal_start_a: assert property (wr && pwdata[2:0] == 3'b100 && !calibrate |-> ##[1:14] calibrate)
		else $error("full apply did not calibrate");
	cal_len_a: assert property ($rose(calibrate) |-> calibrate [*8] ##[30:34] !calibrate)
		else $error("calibration length wrong");
	both_cmd_a: assert property (wr && pwdata[2:0] == 3'b101 && !calibrate |->
		##[1:40] (calibrate && user_word == store_word))
		else $error("combined reload and apply incomplete");
endmodule
bind pcc_top pcc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .enable_pin,
	.enable_pin_active_low, .store_word, .user_word, .pll_word, .calibrate, .clock_buffer_on);

// file: verif/pll_command_control_bench.sv
// pll_command_control_bench: self-checking bench for the pll command block
`timescale 1ns/1ns
module pll_command_control_bench;
	localparam logic [11:0] A = pcc_pkg::PCC_ADDR_ALIAS_A;
	localparam logic [11:0] B = pcc_pkg::PCC_ADDR_ALIAS_B;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic        enable_pin = 1, enable_pin_active_low = 0, user_word_we = 0, calibrate;
	logic        clock_buffer_on;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [33:0] store_word = 34'h2_1234_5678, user_word_in = '0, user_word, pll_word, uw, pe;
	logic [2:0]  v;
	int          seed = 32'hff8e_d5f6, miscompares = 0, comparisons = 0, cycles = 0, i;
	pcc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .enable_pin, .enable_pin_active_low, .store_word, .user_word_in,
		.user_word_we, .user_word, .pll_word, .calibrate, .clock_buffer_on);
	initial begin
		forever #25 pclk = ~pclk;
	end
	// hang guard, far above the few hundred cycles the tests need
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			close_out();
		end
	end
	////////////////////////////////////////
	task automatic chk(input logic [33:0] s, input logic [33:0] e, input string m);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	// one apb transfer; waits an edge first so back-to-back calls never double-drive
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// load a random user word, issue a command, poll until it self-clears
	task automatic cmd(input logic [2:0] c);
		int n;
		n = 0;
		uw = {2'($random(seed)), 32'($random(seed))};
		@(posedge pclk);
		user_word_in <= uw;
		user_word_we <= 1;
		@(posedge pclk);
		user_word_we <= 0;
		apb(1, A, {29'h0, c});
		apb(0, B, 0);
		chk(rd[2:0], c, "command bit not set");
		apb(0, pcc_pkg::PCC_ADDR_STATUS, 0);
		chk(rd[2:0], {c[0], 1'b0, c[2:1] != 2'b00 && !c[0]}, "status busy");
		do begin
			apb(0, A, 0);
			n++;
		end while (rd[2:0] != 3'b000 && n < 40);
		chk(rd[2:0], 3'b000, "command bit stuck");
		chk(user_word, c[0] ? store_word : uw, "user word");
		if (c[2:1] != 2'b00) pe = c[0] ? store_word : uw;
		chk(pll_word, pe, "pll word");
		chk(calibrate, 0, "calibrate left on");
		$display("command %0h test done", c);
	endtask
	task close_out();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		pe = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		apb(0, A, 0);
		chk(rd, 0, "reset value");
		apb(0, 12'h0_008, 0);
		chk(err, 1, "unmapped not refused");
		apb(0, pcc_pkg::PCC_ADDR_STATUS, 0);
		chk(rd, 0, "status after reset");
		chk(err, 0, "status refused");
		$display("reset test done");
		// reserved bits always written as zero
		apb(1, A, 32'h0000_0080);
		apb(0, B, 0);
		chk(rd, 32'h0000_0080, "alias b");
		apb(1, B, 0);
		apb(0, A, 0);
		chk(rd, 0, "alias a");
		$display("alias test done");
		// all eight corners first, then random pin, variant and override
		for (i = 0; i < 24; i++) begin
			v = (i < 8) ? i[2:0] : 3'($random(seed));
			enable_pin_active_low <= v[2];
			enable_pin <= v[1];
			apb(1, B, {24'h0, v[0], 7'h0});
			repeat (4) @(posedge pclk);
			chk(clock_buffer_on, v[0] | (v[1] ^ v[2]), "buffer enable");
		end
		$display("buffer test done");
		cmd(3'b010);
		cmd(3'b100);
		cmd(3'b001);
		cmd(3'b101);
		close_out();
	end
endmodule
